// >>> logic/usf_consts.svh
// Register offsets, field positions, reset values and codes for usf_core.
`ifndef USF_CONSTS_SVH
`define USF_CONSTS_SVH
`define USF_OFF_EFC 8'h00
`define USF_OFF_TXLVL 8'h04
`define USF_OFF_START1 8'h08
`define USF_OFF_START2 8'h0C
`define USF_OFF_STOP1 8'h10
`define USF_OFF_STOP2 8'h14
`define USF_OFF_IER 8'h18
`define USF_OFF_ISR 8'h1C
`define USF_OFF_FCR 8'h20
`define USF_OFF_MCR 8'h24
`define USF_OFF_STAT 8'h28
`define USF_OFF_IRQ_ST 8'h2C
`define USF_OFF_IRQ_CLR 8'h30
`define USF_OFF_IRQ_EN 8'h34
`define USF_EFC_SPECIAL 5
`define USF_EFC_GATE 4
`define USF_EFC_RESET 8'h00
`define USF_TXLVL_RESET 8'h00
`define USF_FIFO128_BIT 0
`define USF_FCR_TXTRIG_LO 4
`define USF_IER_GATED 8'hF0
`define USF_ISR_GATED 8'h30
`define USF_FCR_GATED 8'h30
`define USF_MCR_GATED 8'hE0
`define USF_IRQ_SPECIAL 0
`define USF_IRQ_STOP 1
`define USF_IRQ_START 2
`define USF_IRQ_TXTRIG 3
`define USF_RESP_OKAY 2'b00
`define USF_RESP_SLVERR 2'b10
`endif

// >>> logic/usf_pkg.sv
// Types shared by the flow-control configuration block.
`default_nettype none
package usf_pkg;
   typedef enum logic [1:0]
   {
      TX_IDLE = 2'b00,
      TX_FIRST = 2'b01,
      TX_SECOND = 2'b10
   } usf_tx_st_t;
   typedef struct packed
   {
      logic [7:0] efc;
      logic [7:0] txlvl;
      logic [7:0] start1;
      logic [7:0] start2;
      logic [7:0] stop1;
      logic [7:0] stop2;
      logic [7:0] irq_enable_reg;
      logic [7:0] irq_status_reg;
      logic [7:0] fifo_ctrl_reg;
      logic [7:0] modem_ctrl_reg;
      logic [3:0] irq_st;
      logic [3:0] irq_en;
      logic suspended;
      logic rx_pend_start;
      logic rx_pend_stop;
      logic tx_pend_start;
      logic tx_pend_stop;
      usf_tx_st_t tx_st;
      logic tx_is_stop;
      logic [7:0] tx_data;
      logic tx_valid;
      logic [7:0] rx_data;
      logic rx_valid;
      logic awv;
      logic [7:0] awa;
      logic wv;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } usf_state_t;
endpackage
`default_nettype wire

// >>> logic/usf_core.sv
// UART software flow control, special character detect and tx trigger.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "usf_consts.svh"
////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Special detect: match second stop, store, flag
// - Character bit zero compares received LSB
// - Gate bit permits gated writes; clear freezes
// - Gated settings act with gate clear; reset keeps them
// - Selection bits reset to zero
// - Upper bits pick transmitted flow characters
// - Lower bits pick receive comparison pair
// - Lower 11 with upper not 11 accepts either pair's characters
// - All ones: two-character sequences both ways
// - Trigger level 1..255, zero means one
// - Level register only in 128-byte mode
// - Dual characters sent and matched back-to-back
module usf_core
#(
   parameter int FIFO_DEPTH = 128
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   output logic rx_fifo_valid,
   output logic [7:0] rx_fifo_data,
   input wire logic [7:0] tx_free_spaces,
   input wire logic rx_high,
   input wire logic rx_low,
   output logic tx_suspend,
   output logic tx_flow_valid,
   output logic [7:0] tx_flow_char,
   input wire logic tx_flow_ready,
   output logic [7:0] tx_trigger_level,
   output logic irq
);
   usf_pkg::usf_state_t s_r;
   usf_pkg::usf_state_t s_nxt;
   logic [1:0] txsel;
   logic [1:0] rxsel;
   logic [7:0] lvl128;
   logic [7:0] lvl32;
   logic m_s1;
   logic m_s2;
   logic m_p1;
   logic m_p2;
   logic got_start;
   logic got_stop;
   logic [3:0] ev;
   logic wr_go;
   logic [7:0] wb;
   logic we;

   // Whole-byte compare; bit zero of each character meets the received LSB.
   function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b);
      char_eq = (a[0] == b[0]) && (a[7:1] == b[7:1]);
   endfunction
   // Merge byte lane zero of a write under a mask of writable bits.
   function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [7:0] wd, input logic en, input logic [7:0] msk);
      merge = en ? ((old & ~msk) | (wd & msk)) : old;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // Decode of selection bits and the trigger level.
   assign txsel = s_r.efc[3:2];
   assign rxsel = s_r.efc[1:0];
   assign lvl128 = (s_r.txlvl == 8'h00) ? 8'h01 : s_r.txlvl;
   // In 32-byte mode the level comes from the fifo control trigger field.
   assign lvl32 = {3'b000, s_r.fifo_ctrl_reg[`USF_FCR_TXTRIG_LO+1:`USF_FCR_TXTRIG_LO],
      3'b000} + 8'h01;
   assign tx_trigger_level = s_r.fifo_ctrl_reg[`USF_FIFO128_BIT] ? lvl128
      : lvl32;
   assign m_s1 = char_eq(rx_char, s_r.start1);
   assign m_s2 = char_eq(rx_char, s_r.start2);
   assign m_p1 = char_eq(rx_char, s_r.stop1);
   assign m_p2 = char_eq(rx_char, s_r.stop2);
   assign wr_go = s_r.awv && s_r.wv && !s_r.bvalid;
   assign wb = s_r.wd[7:0];
   assign we = s_r.ws[0];

   ////////////////////////////////////////////////////////////////////////
   // Receive compare: single, either-pair and two-character sequence forms.
   always_comb
   begin
      got_start = 1'b0;
      got_stop = 1'b0;
      if (rx_char_valid)
      begin
         unique case (rxsel)
            2'b10:
            begin
               got_start = m_s1;
               got_stop = m_p1;
            end
            2'b01:
            begin
               got_start = m_s2;
               got_stop = m_p2;
            end
            2'b11:
            begin
               if (txsel == 2'b11)
               begin
                  // Second character must follow the first directly.
                  got_start = s_r.rx_pend_start && m_s2;
                  got_stop = s_r.rx_pend_stop && m_p2;
               end
               else
               begin
                  got_start = m_s1 || m_s2;
                  got_stop = m_p1 || m_p2;
               end
            end
            2'b00:
            begin
               got_start = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of every register, bus channel and flow sequencer.
   always_comb
   begin
      s_nxt = s_r;
      ev = 4'h0;
      // Receive path: characters always pass to the fifo side.
      s_nxt.rx_valid = rx_char_valid;
      if (rx_char_valid)
      begin
         s_nxt.rx_data = rx_char;
         s_nxt.rx_pend_start = m_s1;
         s_nxt.rx_pend_stop = m_p1;
         if (s_r.efc[`USF_EFC_SPECIAL] && m_p2)
         begin
            ev[`USF_IRQ_SPECIAL] = 1'b1;
         end
      end
      // Stop suspends after current character; start resumes.
      if (got_stop)
      begin
         s_nxt.suspended = 1'b1;
         ev[`USF_IRQ_STOP] = 1'b1;
      end
      else if (got_start)
      begin
         s_nxt.suspended = 1'b0;
         ev[`USF_IRQ_START] = 1'b1;
      end
      if (tx_free_spaces >= tx_trigger_level)
      begin
         ev[`USF_IRQ_TXTRIG] = 1'b1;
      end
      // Transmit flow requests: own receive fifo crossing its thresholds.
      if (txsel != 2'b00)
      begin
         if (rx_high)
         begin
            s_nxt.tx_pend_stop = 1'b1;
         end
         if (rx_low)
         begin
            s_nxt.tx_pend_start = 1'b1;
         end
      end
      unique case (s_r.tx_st)
         usf_pkg::TX_IDLE:
         begin
            if (s_nxt.tx_pend_stop || s_nxt.tx_pend_start)
            begin
               s_nxt.tx_is_stop = s_nxt.tx_pend_stop;
               s_nxt.tx_pend_stop = 1'b0;
               if (!s_nxt.tx_is_stop)
               begin
                  s_nxt.tx_pend_start = 1'b0;
               end
               s_nxt.tx_valid = 1'b1;
               s_nxt.tx_st = usf_pkg::TX_FIRST;
               if (txsel == 2'b01)
               begin
                  s_nxt.tx_data = s_nxt.tx_is_stop ? s_r.stop2 : s_r.start2;
               end
               else
               begin
                  s_nxt.tx_data = s_nxt.tx_is_stop ? s_r.stop1 : s_r.start1;
               end
            end
         end
         usf_pkg::TX_FIRST:
         begin
            if (tx_flow_ready)
            begin
               if (txsel == 2'b11)
               begin
                  // Pair goes out back to back.
                  s_nxt.tx_data = s_r.tx_is_stop ? s_r.stop2 : s_r.start2;
                  s_nxt.tx_st = usf_pkg::TX_SECOND;
               end
               else
               begin
                  s_nxt.tx_valid = 1'b0;
                  s_nxt.tx_st = usf_pkg::TX_IDLE;
               end
            end
         end
         usf_pkg::TX_SECOND:
         begin
            if (tx_flow_ready)
            begin
               s_nxt.tx_valid = 1'b0;
               s_nxt.tx_st = usf_pkg::TX_IDLE;
            end
         end
         default:
         begin
            s_nxt.tx_valid = 1'b0;
            s_nxt.tx_st = usf_pkg::TX_IDLE;
         end
      endcase
      // Write channels are taken independently, then answered together.
      if (s_axi_awvalid && !s_r.awv)
      begin
         s_nxt.awv = 1'b1;
         s_nxt.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.wv)
      begin
         s_nxt.wv = 1'b1;
         s_nxt.wd = s_axi_wdata;
         s_nxt.ws = s_axi_wstrb;
      end
      if (wr_go)
      begin
         s_nxt.awv = 1'b0;
         s_nxt.wv = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `USF_RESP_OKAY;
         case (s_r.awa)
            `USF_OFF_EFC: s_nxt.efc = merge(s_r.efc, wb, we, 8'hFF);
            `USF_OFF_TXLVL: s_nxt.txlvl = merge(s_r.txlvl, wb, we, 8'hFF);
            `USF_OFF_START1: s_nxt.start1 = merge(s_r.start1, wb, we, 8'hFF);
            `USF_OFF_START2: s_nxt.start2 = merge(s_r.start2, wb, we, 8'hFF);
            `USF_OFF_STOP1: s_nxt.stop1 = merge(s_r.stop1, wb, we, 8'hFF);
            `USF_OFF_STOP2: s_nxt.stop2 = merge(s_r.stop2, wb, we, 8'hFF);
            // Gated upper bits change only while the gate is set.
            `USF_OFF_IER: s_nxt.irq_enable_reg = merge(s_r.irq_enable_reg, wb, we,
               s_r.efc[`USF_EFC_GATE] ? 8'hFF : ~`USF_IER_GATED);
            `USF_OFF_ISR: s_nxt.irq_status_reg = merge(s_r.irq_status_reg, wb, we,
               s_r.efc[`USF_EFC_GATE] ? 8'hFF : ~`USF_ISR_GATED);
            `USF_OFF_FCR: s_nxt.fifo_ctrl_reg = merge(s_r.fifo_ctrl_reg, wb, we,
               s_r.efc[`USF_EFC_GATE] ? 8'hFF : ~`USF_FCR_GATED);
            `USF_OFF_MCR: s_nxt.modem_ctrl_reg = merge(s_r.modem_ctrl_reg, wb, we,
               s_r.efc[`USF_EFC_GATE] ? 8'hFF : ~`USF_MCR_GATED);
            `USF_OFF_IRQ_CLR:
            begin
               if (s_r.ws[0])
               begin
                  s_nxt.irq_st = s_r.irq_st & ~wb[3:0];
               end
            end
            `USF_OFF_IRQ_EN: s_nxt.irq_en = s_r.ws[0] ? wb[3:0] : s_r.irq_en;
            `USF_OFF_STAT, `USF_OFF_IRQ_ST: s_nxt.bresp = `USF_RESP_OKAY;
            default: s_nxt.bresp = `USF_RESP_SLVERR;
         endcase
      end
      if (s_r.bvalid && s_axi_bready)
      begin
         s_nxt.bvalid = 1'b0;
      end
      // New events win over a same-cycle clear or register write.
      s_nxt.irq_st = s_nxt.irq_st | ev;
      s_nxt.irq_status_reg[4] = s_nxt.irq_status_reg[4] | ev[`USF_IRQ_SPECIAL];
      // Reads answer one cycle after the address is taken.
      if (s_r.rvalid && s_axi_rready)
      begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_r.rvalid)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `USF_RESP_OKAY;
         s_nxt.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            `USF_OFF_EFC: s_nxt.rdata[7:0] = s_r.efc;
            `USF_OFF_TXLVL: s_nxt.rdata[7:0] = s_r.txlvl;
            `USF_OFF_START1: s_nxt.rdata[7:0] = s_r.start1;
            `USF_OFF_START2: s_nxt.rdata[7:0] = s_r.start2;
            `USF_OFF_STOP1: s_nxt.rdata[7:0] = s_r.stop1;
            `USF_OFF_STOP2: s_nxt.rdata[7:0] = s_r.stop2;
            `USF_OFF_IER: s_nxt.rdata[7:0] = s_r.irq_enable_reg;
            `USF_OFF_ISR: s_nxt.rdata[7:0] = s_r.irq_status_reg;
            `USF_OFF_FCR: s_nxt.rdata[7:0] = s_r.fifo_ctrl_reg;
            `USF_OFF_MCR: s_nxt.rdata[7:0] = s_r.modem_ctrl_reg;
            `USF_OFF_STAT: s_nxt.rdata[7:0] = {s_r.tx_valid, s_r.suspended,
               tx_trigger_level[5:0]};
            `USF_OFF_IRQ_ST: s_nxt.rdata[3:0] = s_r.irq_st;
            `USF_OFF_IRQ_EN: s_nxt.rdata[3:0] = s_r.irq_en;
            `USF_OFF_IRQ_CLR: s_nxt.rdata[3:0] = 4'h0;
            default: s_nxt.rresp = `USF_RESP_SLVERR;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register. Gated fields keep their values across a soft reset so
   // the user settings stay in force with the gate clear.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_r <= '0;
         s_r.efc <= `USF_EFC_RESET;
         s_r.txlvl <= `USF_TXLVL_RESET;
         s_r.tx_st <= usf_pkg::TX_IDLE;
         s_r.irq_enable_reg <= s_r.irq_enable_reg & `USF_IER_GATED;
         s_r.irq_status_reg <= s_r.irq_status_reg & `USF_ISR_GATED;
         s_r.fifo_ctrl_reg <= s_r.fifo_ctrl_reg & `USF_FCR_GATED;
         s_r.modem_ctrl_reg <= s_r.modem_ctrl_reg & `USF_MCR_GATED;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign s_axi_awready = !s_r.awv;
   assign s_axi_wready = !s_r.wv;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign rx_fifo_valid = s_r.rx_valid;
   assign rx_fifo_data = s_r.rx_data;
   assign tx_suspend = s_r.suspended;
   assign tx_flow_valid = s_r.tx_valid;
   assign tx_flow_char = s_r.tx_data;
   // Level interrupt: any enabled sticky status bit holds it high.
   assign irq = |(s_r.irq_st & s_r.irq_en);
endmodule
`default_nettype wire

// >>> bench/usf_remote.sv
// Behavioural remote UART on the line side of usf_core.
`timescale 1ns/1ps
`default_nettype none
module usf_remote
(
   input wire logic mclk,
   input wire logic slow,
   input wire logic tx_flow_valid,
   input wire logic [7:0] tx_flow_char,
   output logic tx_flow_ready,
   output logic rx_char_valid,
   output logic [7:0] rx_char
);
   logic [7:0] q[$];
   logic [7:0] got[$];
   logic [1:0] cnt;
   ////////////////////////////////////////////////////////////////////////
   // Characters queued by successive calls leave on consecutive clocks, one per call.
   task send(input logic [7:0] c);
      q.push_back(c);
   endtask
   initial
   begin
      cnt = 2'h0;
      tx_flow_ready = 1'b0;
      rx_char_valid = 1'b0;
      rx_char = 8'h00;
   end
   // A slow far end takes a flow character only one clock in four.
   // Idle line data toggles, so a stale character never looks held.
   always @(posedge mclk)
   begin
      cnt <= cnt + 2'h1;
      tx_flow_ready <= !slow || cnt == 2'h3;
      if (tx_flow_valid && tx_flow_ready)
         got.push_back(tx_flow_char);
      rx_char_valid <= q.size() != 0;
      rx_char <= (q.size() != 0) ? q.pop_front() : ~rx_char;
   end
endmodule
`default_nettype wire

// >>> bench/usf_core_sva.sv
// Port-level assertions for usf_core, bound into the design.
`timescale 1ns/1ps
`default_nettype none
module usf_core_sva
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   input wire logic rx_fifo_valid,
   input wire logic [7:0] rx_fifo_data,
   input wire logic tx_suspend,
   input wire logic tx_flow_valid,
   input wire logic [7:0] tx_flow_char,
   input wire logic tx_flow_ready,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   // Responses stand until taken; a lost response would hang the host.
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   // Both channels land on one edge, the write happens on the next and
   // the response stands from the edge after that.
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no bvalid");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no rvalid");
   rd_upper_a: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
   // Every received character is stored, matched or not.
   rx_store_a: assert property (rx_char_valid |=>
      rx_fifo_valid && rx_fifo_data == $past(rx_char))
      else $error("char not stored");
   rx_quiet_a: assert property (!rx_char_valid |=> !rx_fifo_valid)
      else $error("spurious store");
   flow_hold_a: assert property (tx_flow_valid &&
      !tx_flow_ready |=> tx_flow_valid && $stable(tx_flow_char))
      else $error("flow char moved");
   susp_cause_a: assert property ($changed(tx_suspend) |->
      $past(rx_char_valid)) else $error("suspend moved without char");
   reset_quiet_a: assert property ($fell(reset) |-> !irq && !tx_suspend &&
      !s_axi_bvalid && !s_axi_rvalid) else $error("outputs live after reset");
   // Main scenarios.
   cover property (s_axi_bvalid && s_axi_bready);
   cover property ($rose(tx_suspend));
   cover property (tx_flow_valid && tx_flow_ready);
   cover property ($rose(irq));
endmodule
bind usf_core usf_core_sva sva_i
(
   .mclk(mclk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .rx_char_valid(rx_char_valid),
   .rx_char(rx_char), .rx_fifo_valid(rx_fifo_valid),
   .rx_fifo_data(rx_fifo_data), .tx_suspend(tx_suspend),
   .tx_flow_valid(tx_flow_valid), .tx_flow_char(tx_flow_char),
   .tx_flow_ready(tx_flow_ready), .irq(irq)
);
`default_nettype wire

// >>> bench/usf_core_tb.sv
// Self-checking bench for usf_core.
`timescale 1ns/1ps
`default_nettype none
`include "usf_consts.svh"
module usf_core_tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic rxh = 1'b0, rxl = 1'b0, slow = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, free = 8'h00, v, e;
   logic [31:0] wd = 32'h0000_0000, rd_v, rdat;
   logic awr, wrd, bv, arr, rv, rxv, fv, susp, fval, frdy, irq;
   logic [7:0] rxc, fd, fch, trig;
   logic [1:0] br, rr, rsp;
   logic [7:0] ch [4] = '{8'h11, 8'h13, 8'h19, 8'h93};
   logic [3:0] md [9] = '{4'h0, 4'h8, 4'h4, 4'hC, 4'h2, 4'h1, 4'hB, 4'h7,
      4'hF};
   logic [7:0] eq[$];
   int fail_count = 0, num_checks = 0, seed = 5367, i, k;
   always #2 mclk = ~mclk;
   usf_core uut
   (
      .mclk(mclk), .reset(reset), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .rx_char_valid(rxv), .rx_char(rxc), .rx_fifo_valid(fv),
      .rx_fifo_data(fd), .tx_free_spaces(free), .rx_high(rxh), .rx_low(rxl),
      .tx_suspend(susp), .tx_flow_valid(fval), .tx_flow_char(fch),
      .tx_flow_ready(frdy), .tx_trigger_level(trig), .irq(irq)
   );
   usf_remote rem
   (
      .mclk(mclk), .slow(slow), .tx_flow_valid(fval), .tx_flow_char(fch),
      .tx_flow_ready(frdy), .rx_char_valid(rxv), .rx_char(rxc)
   );
   ////////////////////////////////////////////////////////////////////////
   task final_report();
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x)
      begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, g, x);
      end
   endtask
   // Ready is combinational, so it is judged at the falling edge.
   // Bready rises one clock late so the response is seen waiting.
   task wreg(input logic [7:0] a, input logic [7:0] d);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= {24'h00_0000, d};
      while (pa || pw)
      begin
         @(negedge mclk);
         pa = pa && !awr;
         pw = pw && !wrd;
         @(posedge mclk);
         awv <= pa;
         wv <= pw;
      end
      while (bv !== 1'b1)
         @(posedge mclk);
      bre <= 1'b1;
      @(posedge mclk);
      rsp = br;
      bre <= 1'b0;
   endtask
   task rreg(input logic [7:0] a);
      arv <= 1'b1;
      ara <= a;
      do
         @(negedge mclk);
      while (arr !== 1'b1);
      @(posedge mclk);
      arv <= 1'b0;
      while (rv !== 1'b1)
         @(posedge mclk);
      rre <= 1'b1;
      @(posedge mclk);
      rd_v = rdat;
      rsp = rr;
      rre <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
      rreg(a);
      chk(rd_v[7:0] & m, x);
   endtask
   task rst();
      reset <= 1'b1;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
   endtask
   // Expected flow characters come from the two upper selection bits.
   task flow(input logic hi, input logic [1:0] up);
      eq.delete();
      if (up[1])
         eq.push_back(hi ? ch[2] : ch[0]);
      if (up[0])
         eq.push_back(hi ? ch[3] : ch[1]);
      rem.got.delete();
      rxh <= hi;
      rxl <= !hi;
      @(posedge mclk);
      rxh <= 1'b0;
      rxl <= 1'b0;
      for (k = 0; k < 60 && rem.got.size() < eq.size(); k++)
         @(posedge mclk);
      repeat (8) @(posedge mclk);
      chk(rem.got.size(), eq.size());
      foreach (eq[j])
         chk(rem.got[j], eq[j]);
   endtask
   task schk(input logic [7:0] c, input logic x);
      rem.send(c);
      repeat (4) @(posedge mclk);
      chk(susp, x);
   endtask
   // Whether a lone character of pair k counts as a flow character.
   function logic acc(logic [3:0] m, logic kk);
      return m[1:0] == 2'b11 ? m[3:2] != 2'b11 : m[!kk];
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      final_report();
   end
   initial
   begin
      rst();
      rst();
      rchk(`USF_OFF_EFC, 8'hFF, 8'h00);
      rchk(`USF_OFF_TXLVL, 8'hFF, 8'h00);
      rreg(8'h3C);
      chk(rsp, `USF_RESP_SLVERR);
      wreg(8'h40, 8'h01);
      chk(rsp, `USF_RESP_SLVERR);
      for (i = 0; i < 4; i++)
         wreg(8'h08 + 8'(4 * i), ch[i]);
      // Every mode of the selection table, alternating prompt and slow far end.
      for (i = 0; i < 9; i++)
      begin
         slow <= i[0];
         wreg(`USF_OFF_EFC, {4'h0, md[i]});
         flow(1'b1, md[i][3:2]);
         flow(1'b0, md[i][3:2]);
         schk(ch[2] ^ 8'h01, 1'b0);
         for (k = 0; k < 2; k++)
         begin
            schk(ch[2 + k], acc(md[i], k[0]));
            schk(ch[k], 1'b0);
         end
         rem.send(ch[2]);
         schk(ch[3], md[i][1:0] != 2'b00);
         rem.send(ch[0]);
         schk(ch[1], 1'b0);
      end
      wreg(`USF_OFF_EFC, 8'h20);
      wreg(`USF_OFF_IRQ_CLR, 8'h0F);
      schk(ch[3] ^ 8'h01, 1'b0);
      rchk(`USF_OFF_IRQ_ST, 8'h0F, 8'h00);
      schk(ch[3], 1'b0);
      rchk(`USF_OFF_IRQ_ST, 8'h0F, 8'h01);
      rchk(`USF_OFF_ISR, 8'h10, 8'h10);
      wreg(`USF_OFF_IRQ_EN, 8'h00);
      chk(irq, 1'b0);
      wreg(`USF_OFF_IRQ_EN, 8'h01);
      chk(irq, 1'b1);
      wreg(`USF_OFF_IRQ_CLR, 8'h01);
      chk(irq, 1'b0);
      // Gated bits change only while the gate is set and survive reset.
      wreg(`USF_OFF_EFC, 8'h10);
      wreg(`USF_OFF_IER, 8'hA5);
      rchk(`USF_OFF_IER, 8'hF0, 8'hA0);
      wreg(`USF_OFF_EFC, 8'h00);
      wreg(`USF_OFF_IER, 8'h5A);
      rchk(`USF_OFF_IER, 8'hF0, 8'hA0);
      rst();
      rchk(`USF_OFF_EFC, 8'hFF, 8'h00);
      wreg(`USF_OFF_EFC, 8'h10);
      rchk(`USF_OFF_IER, 8'hF0, 8'hA0);
      wreg(`USF_OFF_FCR, 8'h21);
      for (i = 0; i < 7; i++)
      begin
         v = i == 0 ? 8'h00 : i == 1 ? 8'h01 : i == 2 ? 8'h80 :
            8'h01 + 8'({$random(seed)} % 127);
         e = v == 8'h00 ? 8'h01 : v;
         wreg(`USF_OFF_TXLVL, v);
         chk(trig, e);
         free <= e - 8'h01;
         wreg(`USF_OFF_IRQ_CLR, 8'h08);
         rchk(`USF_OFF_IRQ_ST, 8'h08, 8'h00);
         free <= e;
         // Let the level reach the status bit before the read is taken.
         @(posedge mclk);
         rchk(`USF_OFF_IRQ_ST, 8'h08, 8'h08);
         free <= 8'h00;
      end
      wreg(`USF_OFF_FCR, 8'h20);
      chk(trig, 8'h11);
      wreg(`USF_OFF_EFC, 8'h00);
      wreg(`USF_OFF_FCR, 8'h10);
      chk(trig, 8'h11);
      final_report();
   end
endmodule
`default_nettype wire
